//--- region_checker_params.svh
// register offsets, field positions, reset values of the region checker
`ifndef REGION_CHECKER_PARAMS_SVH
`define REGION_CHECKER_PARAMS_SVH

`define RC_OFS_CTRL 8'h00
`define RC_OFS_FAULT_ADDR 8'h04
`define RC_OFS_FAULT_INFO 8'h08
`define RC_OFS_REGION0 8'h10
`define RC_REGION_STRIDE_LOG2 3
`define RC_OFS_REGION_END 8'h50

`define RC_CTRL_ENABLE 0
`define RC_CTRL_DEFAULT 1

`define RC_ATTR_ENABLE 0
`define RC_ATTR_SIZE_LO 1
`define RC_ATTR_SIZE_HI 5
`define RC_ATTR_PERM_LO 8
`define RC_ATTR_PERM_HI 10
`define RC_ATTR_XN 12

`define RC_INFO_VALID 0
`define RC_INFO_KIND_LO 1
`define RC_INFO_KIND_HI 2
`define RC_INFO_PRIV 3
`define RC_INFO_REGION_LO 4
`define RC_INFO_REGION_HI 6
`define RC_INFO_DEFAULT 8

`define RC_RST_CTRL 2'h0
`define RC_RST_BASE 27'h0000000
`define RC_MIN_SIZE 5'h04

`endif

//--- region_checker_pkg.sv
// types shared by the region checker and its bench
`default_nettype none
package region_checker_pkg;

  typedef enum logic [1:0] {
    KIND_READ = 2'h0,
    KIND_WRITE = 2'h1,
    KIND_FETCH = 2'h2
  } access_kind_t;

  typedef enum logic [2:0] {
    PERM_NONE_NONE = 3'h0,
    PERM_RW_NONE = 3'h1,
    PERM_RW_RO = 3'h2,
    PERM_RW_RW = 3'h3,
    PERM_RO_NONE = 3'h5,
    PERM_RO_RO = 3'h6
  } perm_t;

  typedef struct packed {
    logic [31:0] addr;
    access_kind_t kind;
    logic priv;
  } access_req_t;

  typedef struct packed {
    logic execute_never_bit;
    logic [2:0] perm;
    logic [4:0] size;
    logic enable;
  } region_cfg_t;

endpackage
`default_nettype wire

//--- region_access_checker.sv
// region based access checker with an AXI4-Lite configuration slave
// Behaviour
// - with the checker disabled every access of either privilege is granted.
// - among several enabled regions that match, only the top one decides.
// - region priority rises with index, region 7 above region 0.
// - an address in no enabled region is judged by the default region bit.
// - the chosen region checks privilege against the operation, else faults.
// - a set execute-never bit in the chosen region forbids every fetch.
// - with execute-never clear, a fetch is judged exactly as a read.
// - the no-access setting faults every access of both privileges.
// - privileged read/write with user none allows privileged, faults user.
// - privileged rw with user read-only faults user writes only.
// - a privileged read-only setting faults privileged writes.
// - eight regions each hold enable, execute-never, base, size, permission.
// - one control bit sets the behaviour of the default region.
// - each access carries a privilege flag from the core.
`include "region_checker_params.svh"
`default_nettype none

module region_access_checker #(
  parameter int REGIONS = 8
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  // access port from the core
  input wire logic REQ_VALID,
  input wire region_checker_pkg::access_req_t REQ,
  // towards memory
  output var logic MEM_VALID,
  output var region_checker_pkg::access_req_t MEM_REQ,
  // answer to the core
  output var logic RSP_VALID,
  output var logic RSP_FAULT,
  // AXI4-Lite slave
  input wire logic [7:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output var logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output var logic WREADY,
  output var logic [1:0] BRESP,
  output var logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output var logic ARREADY,
  output var logic [31:0] RDATA,
  output var logic [1:0] RRESP,
  output var logic RVALID,
  input wire logic RREADY
);
  import region_checker_pkg::*;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] size_mask(input logic [4:0] sz);
    logic [4:0] s;
    s = (sz < `RC_MIN_SIZE) ? `RC_MIN_SIZE : sz;
    // six bits so that a 4 GB region shifts the mask away to zero
    size_mask = 32'hFFFFFFFF << ({1'b0, s} + 6'h01);
  endfunction

  // rights per privilege: {priv_read, priv_write, user_read, user_write}
  function automatic logic [3:0] perm_rights(input logic [2:0] p);
    case (p)
      PERM_NONE_NONE: perm_rights = 4'h0;
      PERM_RW_NONE: perm_rights = 4'hC;
      PERM_RW_RO: perm_rights = 4'hE;
      PERM_RW_RW: perm_rights = 4'hF;
      PERM_RO_NONE: perm_rights = 4'h8;
      PERM_RO_RO: perm_rights = 4'hA;
      default: perm_rights = 4'h0;
    endcase
  endfunction

  function automatic logic rights_allow(input logic [3:0] r,
                                        input logic priv,
                                        input access_kind_t kind,
                                        input logic xn);
    logic rd;
    logic wr;
    rd = priv ? r[3] : r[1];
    wr = priv ? r[2] : r[0];
    case (kind)
      KIND_READ: rights_allow = rd;
      KIND_WRITE: rights_allow = wr;
      KIND_FETCH: rights_allow = rd & ~xn;
      default: rights_allow = 1'b0;
    endcase
  endfunction

  // region slot of a byte offset, or all ones when outside the region area
  function automatic logic [3:0] region_slot(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - `RC_OFS_REGION0;
    if (a >= `RC_OFS_REGION0 && a < `RC_OFS_REGION_END) begin
      region_slot = {1'b0,
        rel[`RC_REGION_STRIDE_LOG2 + 2:`RC_REGION_STRIDE_LOG2]};
    end else begin
      region_slot = 4'hF;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration state

  logic enable;
  logic default_allow;
  logic [26:0] region_base [REGIONS];
  region_cfg_t region_cfg [REGIONS];
  logic [31:0] fault_addr;
  logic [8:0] fault_info;

  ////////////////////////////////////////////////////////////////////////////
  // region match and priority

  logic [REGIONS-1:0] hit;

  genvar gi;
  generate
    for (gi = 0; gi < REGIONS; gi++) begin : g_match
      assign hit[gi] = region_cfg[gi].enable &&
        (((REQ.addr ^ {region_base[gi], 5'h00}) &
          size_mask(region_cfg[gi].size)) == 32'h00000000);
    end
  endgenerate

  logic any_hit;
  logic [2:0] top_idx;

  // highest index wins, so a later loop pass overrides an earlier one
  always_comb begin
    top_idx = 3'h0;
    for (int i = 0; i < REGIONS; i++) begin
      if (hit[i]) begin
        top_idx = 3'(i);
      end
    end
  end

  assign any_hit = |hit;

  region_cfg_t top_cfg;
  logic region_ok;
  logic default_ok;
  logic access_ok;

  assign top_cfg = region_cfg[top_idx];
  assign region_ok = rights_allow(perm_rights(top_cfg.perm), REQ.priv,
                                  REQ.kind, top_cfg.execute_never_bit);
  // with the default bit set the default region grants privileged code everything, else nobody; users never
  assign default_ok = default_allow & REQ.priv;
  assign access_ok = !enable ? 1'b1 :
                     any_hit ? region_ok : default_ok;

  ////////////////////////////////////////////////////////////////////////////
  // access pipeline: one registered stage, memory sees only granted ones

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      MEM_VALID <= 1'b0;
      MEM_REQ <= '0;
      RSP_VALID <= 1'b0;
      RSP_FAULT <= 1'b0;
    end else begin
      MEM_VALID <= REQ_VALID & access_ok;
      MEM_REQ <= REQ;
      RSP_VALID <= REQ_VALID;
      RSP_FAULT <= REQ_VALID & ~access_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  logic aw_held;
  logic w_held;
  logic [7:0] wr_addr;
  logic wr_priv;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic do_write;
  logic [3:0] wr_slot;
  logic wr_mapped;
  logic wr_allowed;
  logic [31:0] wr_mask;

  assign do_write = aw_held && w_held && !BVALID;
  assign wr_slot = region_slot(wr_addr);
  assign wr_mapped = (wr_addr == `RC_OFS_CTRL) ||
                     (wr_addr == `RC_OFS_FAULT_ADDR) ||
                     (wr_addr == `RC_OFS_FAULT_INFO) ||
                     (wr_slot != 4'hF && wr_addr[1:0] == 2'h0);
  assign wr_allowed = wr_mapped && wr_priv;
  assign wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                    {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_priv <= 1'b0;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        AWREADY <= 1'b0;
        wr_addr <= AWADDR;
        wr_priv <= AWPROT[0];
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        WREADY <= 1'b0;
        wr_data <= WDATA;
        wr_strb <= WSTRB;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= wr_allowed ? RESP_OKAY : RESP_SLVERR;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  logic ctrl_we;
  logic info_clear;

  assign ctrl_we = do_write && wr_allowed && wr_addr == `RC_OFS_CTRL &&
                   wr_strb[0];
  assign info_clear = do_write && wr_allowed &&
                      wr_addr == `RC_OFS_FAULT_INFO && wr_strb[0] &&
                      wr_data[`RC_INFO_VALID];

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      enable <= 1'(`RC_RST_CTRL >> `RC_CTRL_ENABLE);
      default_allow <= 1'(`RC_RST_CTRL >> `RC_CTRL_DEFAULT);
    end else if (ctrl_we) begin
      enable <= wr_data[`RC_CTRL_ENABLE];
      default_allow <= wr_data[`RC_CTRL_DEFAULT];
    end
  end

  generate
    for (gi = 0; gi < REGIONS; gi++) begin : g_region
      logic base_we;
      logic attr_we;
      logic [31:0] base_word;
      logic [31:0] attr_word;
      assign base_we = do_write && wr_allowed && wr_slot == 4'(gi) &&
                       !wr_addr[2];
      assign attr_we = do_write && wr_allowed && wr_slot == 4'(gi) &&
                       wr_addr[2];
      assign base_word = ({region_base[gi], 5'h00} & ~wr_mask) |
                         (wr_data & wr_mask);
      assign attr_word = ({19'h00000, region_cfg[gi].execute_never_bit, 1'b0,
                           region_cfg[gi].perm, 2'h0, region_cfg[gi].size,
                           region_cfg[gi].enable} & ~wr_mask) |
                         (wr_data & wr_mask);
      always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
          region_base[gi] <= `RC_RST_BASE;
          region_cfg[gi] <= '0;
        end else begin
          if (base_we) begin
            region_base[gi] <= base_word[31:5];
          end
          if (attr_we) begin
            region_cfg[gi].enable <= attr_word[`RC_ATTR_ENABLE];
            region_cfg[gi].size <=
              attr_word[`RC_ATTR_SIZE_HI:`RC_ATTR_SIZE_LO];
            region_cfg[gi].perm <=
              attr_word[`RC_ATTR_PERM_HI:`RC_ATTR_PERM_LO];
            region_cfg[gi].execute_never_bit <= attr_word[`RC_ATTR_XN];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // fault capture: sticky, a new fault wins over a clear in the same cycle

  logic fault_now;
  assign fault_now = REQ_VALID && !access_ok;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      fault_addr <= 32'h00000000;
      fault_info <= 9'h000;
    end else if (fault_now) begin
      fault_addr <= REQ.addr;
      fault_info <= {!any_hit, 1'b0, top_idx, REQ.priv, REQ.kind, 1'b1};
    end else if (info_clear) begin
      fault_info[`RC_INFO_VALID] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic [3:0] rd_slot;
  logic rd_mapped;
  logic [31:0] rd_word;
  region_cfg_t rd_cfg;

  assign rd_slot = region_slot(ARADDR);
  assign rd_cfg = region_cfg[rd_slot[2:0]];
  assign rd_mapped = (ARADDR == `RC_OFS_CTRL) ||
                     (ARADDR == `RC_OFS_FAULT_ADDR) ||
                     (ARADDR == `RC_OFS_FAULT_INFO) ||
                     (rd_slot != 4'hF && ARADDR[1:0] == 2'h0);
  assign rd_word =
    (ARADDR == `RC_OFS_CTRL) ? {30'h00000000, default_allow, enable} :
    (ARADDR == `RC_OFS_FAULT_ADDR) ? fault_addr :
    (ARADDR == `RC_OFS_FAULT_INFO) ? {23'h000000, fault_info} :
    (rd_slot == 4'hF || !rd_mapped) ? 32'h00000000 :
    !ARADDR[2] ? {region_base[rd_slot[2:0]], 5'h00} :
    {19'h00000, rd_cfg.execute_never_bit, 1'b0, rd_cfg.perm, 2'h0,
     rd_cfg.size, rd_cfg.enable};

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= RESP_OKAY;
    end else begin
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RDATA <= rd_word;
        RRESP <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

//--- region_access_checker_chk.sv
// port assertions of the region access checker
`default_nettype none
module region_access_checker_chk (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic REQ_VALID,
  input wire region_checker_pkg::access_req_t REQ,
  input wire logic MEM_VALID,
  input wire region_checker_pkg::access_req_t MEM_REQ,
  input wire logic RSP_VALID,
  input wire logic RSP_FAULT,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID
);
  timeunit 1ns;
  timeprecision 1ns;
  import region_checker_pkg::*;
  logic cfg_written;

  // any accepted write address may change the setup
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_written <= 1'h0;
    end else if (AWVALID && AWREADY) begin
      cfg_written <= 1'h1;
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);

  sequence aw_take_s;
    AWVALID && AWREADY;
  endsequence
  sequence slverr_s;
    BVALID && BRESP == 2'h2;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  rsp_follow_a: assert property (REQ_VALID |=> RSP_VALID)
    else $error("access got no answer");
  idle_quiet_a: assert property (
    !REQ_VALID |=> !RSP_VALID && !MEM_VALID && !RSP_FAULT)
    else $error("answer without access");
  grant_excl_a: assert property (
    RSP_VALID |-> MEM_VALID != RSP_FAULT)
    else $error("fault and grant disagree");
  mem_copy_a: assert property (MEM_VALID |-> MEM_REQ == $past(REQ))
    else $error("memory request differs");
  open_access_a: assert property (
    !cfg_written && REQ_VALID |=> !RSP_FAULT)
    else $error("fault while disabled");
  user_write_a: assert property (
    aw_take_s and !AWPROT[0] |-> ##[1:8] slverr_s)
    else $error("user write not refused");
  write_answer_a: assert property (aw_take_s |-> ##[1:8] BVALID)
    else $error("write not answered");
  read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read not answered");
endmodule

bind region_access_checker region_access_checker_chk i_region_access_chk (
  .CORE_CLK, .NRST, .REQ_VALID, .REQ, .MEM_VALID, .MEM_REQ, .RSP_VALID,
  .RSP_FAULT, .AWPROT, .AWVALID, .AWREADY, .BRESP, .BVALID, .ARVALID,
  .ARREADY, .RVALID
);
`default_nettype wire

//--- core_access_model.sv
// core side model issuing one access per cycle on request
`default_nettype none
module core_access_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic issue,
  input wire region_checker_pkg::access_req_t next_req,
  output var logic req_valid,
  output var region_checker_pkg::access_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  import region_checker_pkg::*;

  // idle request bus keeps toggling so stale values never look valid
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_valid <= 1'h0;
      req <= '0;
    end else begin
      req_valid <= issue;
      req <= issue ? next_req : access_req_t'(~req);
    end
  end
endmodule
`default_nettype wire

//--- region_access_checker_tb.sv
// self-checking bench of the region access checker
`default_nettype none
module region_access_checker_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import region_checker_pkg::*;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic issue = 1'h0;
  access_req_t nreq = '0;
  access_req_t req, mem_req;
  logic req_valid, mem_valid, rsp_valid, rsp_fault;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [2:0] awprot = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int error_cnt = 0;
  int check_count = 0;
  bit en, dflt;
  bit [31:0] rbase [8];
  int rsize [8], rperm [8];
  bit ren [8], rxn [8];
  bit exp_q [$];
  access_req_t req_q [$];
  access_req_t last_den = '0;

  always #50 clk = ~clk;

  core_access_model i_core_access_model (.clk(clk), .nrst(nrst),
    .issue(issue), .next_req(nreq), .req_valid(req_valid), .req(req));

  region_access_checker i_region_access_checker (.CORE_CLK(clk),
    .NRST(nrst), .REQ_VALID(req_valid), .REQ(req), .MEM_VALID(mem_valid),
    .MEM_REQ(mem_req), .RSP_VALID(rsp_valid), .RSP_FAULT(rsp_fault),
    .AWADDR(awaddr), .AWPROT(awprot), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARPROT(3'h0), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

  ////////////////////////////////////////////////////////////////////////////
  function automatic bit denied(access_req_t r);
    int hit;
    bit rd, wr;
    hit = -1;
    if (!en) return 1'h0;
    for (int i = 0; i < 8; i++) begin
      if (ren[i] && ((r.addr ^ rbase[i]) >> (rsize[i] + 1)) == 0) hit = i;
    end
    if (hit < 0) return !(dflt && r.priv);
    rd = r.priv ? rperm[hit] inside {1, 2, 3, 5, 6}
                : rperm[hit] inside {2, 3, 6};
    wr = r.priv ? rperm[hit] inside {1, 2, 3} : rperm[hit] == 3;
    if (r.kind == KIND_WRITE) return !wr;
    if (r.kind == KIND_FETCH) return !rd || rxn[hit];
    return !rd;
  endfunction

  task automatic fail(string m);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic cmp(logic [34:0] got, logic [34:0] exp, string m);
    check_count++;
    if (got !== exp) fail(m);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (rsp_valid === 1'h1) begin
      if (exp_q.size() == 0) begin
        fail("answer without access");
      end else begin
        cmp(rsp_fault, exp_q[0], "fault flag");
        cmp(mem_valid, !exp_q[0], "memory grant");
        if (!exp_q[0]) cmp(mem_req, req_q[0], "memory request");
        void'(exp_q.pop_front());
        void'(req_q.pop_front());
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(logic [7:0] a, logic [31:0] d, logic p, logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awprot <= {2'h0, p};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready === 1'h1) awvalid <= 1'h0;
      if (wvalid && wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    bready <= 1'h0;
    if (n == 50) fail("write timeout");
    cmp(bresp, er, "write response");
    @(posedge clk);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    rready <= 1'h0;
    if (n == 50) fail("read timeout");
    cmp(rdata, ed, "read data");
    cmp(rresp, er, "read response");
    @(posedge clk);
  endtask

  task automatic ctrl(bit e, bit d, bit p);
    wr(8'h00, {30'h0, d, e}, p, p ? 2'h0 : 2'h2);
    if (p) begin
      en = e;
      dflt = d;
    end
  endtask

  task automatic region(int i, bit [31:0] b, int s, int pm, bit x, bit e);
    logic [31:0] at;
    at = {19'h0, x, 1'h0, pm[2:0], 2'h0, s[4:0], e};
    wr(8'(8'h10 + 8 * i), b, 1'h1, 2'h0);
    wr(8'(8'h14 + 8 * i), at, 1'h1, 2'h0);
    rd(8'(8'h14 + 8 * i), at, 2'h0);
    rbase[i] = b & 32'hFFFF_FFE0;
    rsize[i] = s;
    rperm[i] = pm;
    rxn[i] = x;
    ren[i] = e;
  endtask

  task automatic acc(logic [31:0] a, access_kind_t k, logic p);
    access_req_t r;
    r = '{a, k, p};
    issue <= 1'h1;
    nreq <= r;
    exp_q.push_back(denied(r));
    if (exp_q[$]) last_den = r;
    req_q.push_back(r);
    @(posedge clk);
  endtask

  task automatic burst(int n, bit [31:0] m, string name);
    int w;
    for (int j = 0; j < n; j++) begin
      acc($urandom & m, access_kind_t'($urandom_range(0, 2)),
          1'($urandom_range(0, 1)));
    end
    issue <= 1'h0;
    for (w = 0; w < 20 && exp_q.size() > 0; w++) @(posedge clk);
    if (exp_q.size() > 0) fail("missing answer");
    $display("test %s done", name);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    fail("run timeout");
    test_done();
  end

  initial begin
    void'($urandom(32'hCC71));
    repeat (12) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h60, 32'h0, 2'h2);
    burst(24, 32'hFFFF_FFFF, "disabled");
    ctrl(1'h1, 1'h1, 1'h0);
    rd(8'h00, 32'h0, 2'h0);
    burst(12, 32'hFFFF_FFFF, "user setup refused");
    ctrl(1'h1, 1'h0, 1'h1);
    burst(12, 32'hFFFF_FFFF, "default deny");
    rd(8'h04, last_den.addr, 2'h0);
    rd(8'h08, {23'h0, 2'h2, 3'h0, last_den.priv, last_den.kind, 1'h1},
       2'h0);
    wr(8'h08, 32'h1, 1'h1, 2'h0);
    rd(8'h08, {23'h0, 2'h2, 3'h0, last_den.priv, last_den.kind, 1'h0},
       2'h0);
    ctrl(1'h1, 1'h1, 1'h1);
    burst(12, 32'hFFFF_FFFF, "default privileged");
    for (int c = 0; c < 12; c++) begin
      // codes 4 and 7 are left to the random rounds
      region(0, 32'h1000, 4, (c / 2 > 3) ? c / 2 + 1 : c / 2, c % 2, 1'h1);
      for (int k = 0; k < 6; k++) begin
        acc(32'h1010, access_kind_t'(k / 2), 1'(k % 2));
      end
      burst(0, 32'h0, "permission code");
    end
    for (int t = 0; t < 4; t++) begin
      for (int i = 0; i < 8; i++) begin
        region(i, $urandom & 32'h1FE0, $urandom_range(4, 9),
               $urandom_range(0, 7), 1'($urandom), 1'($urandom));
      end
      ctrl(1'h1, 1'($urandom), 1'h1);
      burst(40, 32'h1FFF, "overlapping regions");
    end
    test_done();
  end
endmodule
`default_nettype wire
